/* hw/slb_init_pulse.sv */
// Purpose: Low, high, low start-up pulse, each state a fixed tick count.
// Assumes: Start is a one-cycle pulse; tick is one cycle per clock period.
// Notes:   Done is a one-cycle pulse in the cycle after the tick that ends the last state.
`timescale 1ns/1ps
module slb_init_pulse
  import slb_pkg::*;
(
  input  wire logic   clk_in,
  input  wire logic   arst_n_in,
  input  wire logic   ce_in,
  input  wire logic   abort_in,
  slb_init_if.gen     p
);
  slb_pulse_t st_q;
  logic [3:0] cnt_q;
  logic       done_q;

  assign p.level = (st_q == P_HIGH);
  assign p.busy  = (st_q != P_IDLE);
  assign p.done  = done_q;

  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      st_q   <= P_IDLE;
      cnt_q  <= 4'h0;
      done_q <= 1'b0;
    end
    else if (ce_in)
    begin
      done_q <= 1'b0;
      if (abort_in)
      begin
        st_q  <= P_IDLE;
        cnt_q <= 4'h0;
      end
      else if (st_q == P_IDLE)
      begin
        cnt_q <= 4'h0;
        if (p.start)
          st_q <= P_LOW1;
      end
      else if (p.tick)
      begin
        if (cnt_q == INIT_STATE_CYC - 4'h1)
        begin
          cnt_q <= 4'h0;
          unique case (st_q)
            P_LOW1: st_q <= P_HIGH;
            P_HIGH: st_q <= P_LOW2;
            P_LOW2:
            begin
              st_q   <= P_IDLE;
              done_q <= 1'b1;
            end
            default: st_q <= P_IDLE;
          endcase
        end
        else
          cnt_q <= cnt_q + 4'h1;
      end
    end
  end
endmodule

/* hw/slb_link_top.sv */
// Purpose: Link state and bring-up sequencer for either end of the link.
// Assumes: All pins are asynchronous and pass two flip-flops first.
// Notes:   Link clocks must be well below a quarter of the core clock.
// What this block does
// - Forward link is serial clock plus data.
// - Data sampled on both serial clock edges.
// - Phase decoded as off, initialising or active.
// - Reference starts first, then serial clock, then data.
// - Sleep switches every link line off.
// - Deserializer starts far end via reverse clock.
// - Deserializer waits 7 reference cycles first.
// - Reverse line low, high, low, 12 each.
// - Serial clock low, high, low, 12 each.
// - Reference and serial clocks treated as unrelated.
// - Serializer forwards after 7, locks 7 later.
// - Power-down switches off the reverse line.
// - Align on first rising edge, LSB first.
// - Serial clock runs five times pixel rate.
`timescale 1ns/1ps
module slb_link_top
  import slb_pkg::*;
(
  input  wire logic                  clk_in,
  input  wire logic                  arst_n_in,
  input  wire logic                  ce_in,
  input  wire logic                  power_down_n_in,
  input  wire logic                  role_ser_in,
  input  wire logic                  ref_clock_pin_in,
  output logic                       ref_clock_pin_out,
  input  wire logic                  reverse_ref_clock_line_in,
  input  wire logic                  reverse_ref_clock_line_on_in,
  output logic                       reverse_ref_clock_line_out,
  output logic                       reverse_ref_clock_line_on_out,
  input  wire logic                  serial_clock_line_in,
  input  wire logic                  serial_clock_line_on_in,
  output logic                       serial_clock_line_out,
  output logic                       serial_clock_line_on_out,
  input  wire logic                  serial_data_line_in,
  input  wire logic                  serial_data_line_on_in,
  output logic                       serial_data_line_out,
  output logic                       serial_data_line_on_out,
  input  wire logic                  pixel_clock_in,
  input  wire logic [WORD_W-1:0]     pixel_word_in,
  output logic [WORD_W-1:0]          rx_word_out,
  output logic                       rx_valid_out,
  output slb_pkg::slb_phase_t        link_phase_out
);
  import slb_pkg::*;

  function automatic logic rise(input logic now, input logic was);
    rise = now & ~was;
  endfunction

  function automatic slb_phase_t phase_of(input logic ref_on,
                                          input logic clk_on,
                                          input logic dat_on);
    if (dat_on && clk_on)
      phase_of = PH_ACTIVE;
    else if (clk_on)
      phase_of = PH_INIT_SER;
    else if (ref_on)
      phase_of = PH_INIT_REF;
    else
      phase_of = PH_OFF;
  endfunction

  // Every pin crosses into the core clock here; stage one feeds stage two
  // only, and stage three serves edge detection.
  logic [SYNC_W-1:0] s1_q;
  logic [SYNC_W-1:0] s2_q;
  logic [SYNC_W-1:0] s3_q;

  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end
    else if (ce_in)
    begin
      s1_q <= {pixel_word_in, pixel_clock_in, serial_data_line_on_in,
               serial_data_line_in, serial_clock_line_on_in,
               serial_clock_line_in, reverse_ref_clock_line_on_in,
               reverse_ref_clock_line_in, ref_clock_pin_in, role_ser_in,
               power_down_n_in};
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  logic              pd_n;
  logic              role_s;
  logic              ref_pin;
  logic              wc_in;
  logic              wc_on_in;
  logic              mc_in;
  logic              mc_on_in;
  logic              md_in;
  logic              md_on_in;
  logic [WORD_W-1:0] pix_word;
  logic              ref_rise;
  logic              wc_rise;
  logic              mc_edge;
  logic              mc_rise;
  logic              pix_rise;

  assign pd_n     = s2_q[0];
  assign role_s   = s2_q[1];
  assign ref_pin  = s2_q[2];
  assign wc_in    = s2_q[3];
  assign wc_on_in = s2_q[4];
  assign mc_in    = s2_q[5];
  assign mc_on_in = s2_q[6];
  assign md_in    = s2_q[7];
  assign md_on_in = s2_q[8];
  assign pix_word = s2_q[SYNC_W-1:SYNC_W-WORD_W];
  assign ref_rise = rise(s2_q[2], s3_q[2]);
  assign wc_rise  = rise(s2_q[3], s3_q[3]);
  assign mc_edge  = s2_q[5] ^ s3_q[5];
  assign mc_rise  = rise(s2_q[5], s3_q[5]);
  assign pix_rise = rise(s2_q[9], s3_q[9]);

  // The role strap is caught once, only after it has crossed both sync
  // stages; earlier the stages still hold their reset zero.
  logic       role_q;
  logic       role_taken_q;
  logic [1:0] role_wait_q;

  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      role_q       <= 1'b0;
      role_taken_q <= 1'b0;
      role_wait_q  <= 2'h0;
    end
    else if (ce_in && !role_taken_q)
    begin
      if (role_wait_q == 2'h2)
      begin
        role_q       <= role_s;
        role_taken_q <= 1'b1;
      end
      else
        role_wait_q <= role_wait_q + 2'h1;
    end
  end

  slb_init_if ip ();
  slb_seq_t   st_q;
  logic [3:0] edge_cnt_q;
  logic       ref_tick;
  logic       gen_q;
  logic       gen_fall;

  // Each start-up pulse counts cycles of its own clock only.
  assign ref_tick = role_q ? wc_rise : ref_rise;
  assign ip.tick  = role_q ? gen_fall : ref_rise;
  assign ip.start = (st_q == S_WAIT1) && !role_q && ref_tick &&
                    (edge_cnt_q == REF_WAIT_EDGES - 4'h1) ||
                    (st_q == S_LOCK) && pix_rise && (edge_cnt_q != 4'h0);

  slb_init_pulse u_pulse (
    .clk_in    (clk_in),
    .arst_n_in (arst_n_in),
    .ce_in     (ce_in),
    .abort_in  (!pd_n),
    .p         (ip)
  );

  // Pixel clock presence watch.
  logic [11:0] pix_idle_q;
  logic        pix_ok;

  assign pix_ok = (pix_idle_q < PIX_LOST_CYC);

  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      pix_idle_q <= PIX_LOST_CYC;
    else if (ce_in)
    begin
      if (pix_rise)
        pix_idle_q <= 12'h000;
      else if (pix_ok)
        pix_idle_q <= pix_idle_q + 12'h001;
    end
  end

  // Bring-up sequencer.
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      st_q       <= S_OFF;
      edge_cnt_q <= 4'h0;
    end
    else if (ce_in)
    begin
      if (!pd_n || (role_q && !wc_on_in && st_q != S_OFF))
      begin
        st_q       <= S_OFF;
        edge_cnt_q <= 4'h0;
      end
      else
        unique case (st_q)
          S_OFF:
            if (!role_q || wc_on_in)
              st_q <= S_WAIT1;
          S_WAIT1:
            if (ref_tick)
            begin
              if (edge_cnt_q == REF_WAIT_EDGES - 4'h1)
              begin
                edge_cnt_q <= 4'h0;
                st_q       <= role_q ? S_WAIT2 : S_INIT;
              end
              else
                edge_cnt_q <= edge_cnt_q + 4'h1;
            end
          S_WAIT2:
            if (ref_tick && edge_cnt_q != LOCK_WAIT_EDGES)
              edge_cnt_q <= edge_cnt_q + 4'h1;
            else if (edge_cnt_q == LOCK_WAIT_EDGES && pix_ok)
            begin
              edge_cnt_q <= 4'h0;
              st_q       <= S_LOCK;
            end
          S_LOCK:
            if (pix_rise)
            begin
              edge_cnt_q <= 4'h1;
              if (edge_cnt_q != 4'h0)
                st_q <= S_INIT;
            end
          S_INIT:
            if (ip.done)
              st_q <= S_RUN;
          S_RUN:
            st_q <= S_RUN;
        endcase
    end
  end

  // Serial clock generator: the pixel period is measured and split into
  // ten half periods, so five serial cycles carry one ten-bit word.
  logic [11:0] per_cnt_q;
  logic [11:0] half_q;
  logic [11:0] hcnt_q;
  logic        gen_tog;
  logic        gen_run;

  assign gen_run  = (st_q == S_INIT) || (st_q == S_RUN);
  assign gen_tog  = gen_run && (hcnt_q >= half_q - 12'h001);
  assign gen_fall = gen_tog && gen_q;

  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      per_cnt_q <= 12'h000;
      half_q    <= 12'h001;
      hcnt_q    <= 12'h000;
      gen_q     <= 1'b0;
    end
    else if (ce_in)
    begin
      if (st_q == S_LOCK)
      begin
        per_cnt_q <= pix_rise ? 12'h000 : per_cnt_q + 12'h001;
        if (pix_rise && edge_cnt_q != 4'h0)
          half_q <= 12'((per_cnt_q + 12'h001) / (2 * SER_CLK_MULT));
      end
      if (!gen_run)
      begin
        hcnt_q <= 12'h000;
        gen_q  <= 1'b0;
      end
      else if (gen_tog)
      begin
        hcnt_q <= 12'h000;
        gen_q  <= ~gen_q;
      end
      else
        hcnt_q <= hcnt_q + 12'h001;
    end
  end

  // Transmit shifter: each bit is set up mid-way through the half period
  // before its edge, so it is stable around that edge.
  logic [3:0]        tx_idx_q;
  logic [WORD_W-1:0] tx_word_q;
  logic [WORD_W-1:0] tx_hold_q;
  logic              md_q;

  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      tx_idx_q  <= 4'h0;
      tx_word_q <= '0;
      tx_hold_q <= '0;
      md_q      <= 1'b0;
    end
    else if (ce_in)
    begin
      if (pix_rise)
        tx_hold_q <= pix_word;
      if (st_q != S_RUN)
      begin
        tx_idx_q <= 4'h0;
        md_q     <= 1'b0;
      end
      else
      begin
        if (hcnt_q == (half_q >> 1))
        begin
          if (tx_idx_q == 4'h0)
          begin
            tx_word_q <= tx_hold_q;
            md_q      <= tx_hold_q[0];
          end
          else
            md_q <= tx_word_q[tx_idx_q];
        end
        if (gen_tog)
          tx_idx_q <= (tx_idx_q == BITS_PER_WORD - 4'h1) ?
                      4'h0 : tx_idx_q + 4'h1;
      end
    end
  end

  // Receiver: one bit per clock edge, word framed from the first rising
  // edge once the data line carries current.
  logic [WORD_W-1:0] rx_sh_q;
  logic [3:0]        rx_cnt_q;

  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      rx_sh_q      <= '0;
      rx_cnt_q     <= 4'h0;
      rx_word_out  <= '0;
      rx_valid_out <= 1'b0;
    end
    else if (ce_in)
    begin
      rx_valid_out <= 1'b0;
      if (!pd_n || role_q || !md_on_in || !mc_on_in)
        rx_cnt_q <= 4'h0;
      else if (mc_edge && (rx_cnt_q != 4'h0 || mc_rise))
      begin
        rx_sh_q <= {md_in, rx_sh_q[WORD_W-1:1]};
        if (rx_cnt_q == BITS_PER_WORD - 4'h1)
        begin
          rx_cnt_q     <= 4'h0;
          rx_word_out  <= {md_in, rx_sh_q[WORD_W-1:1]};
          rx_valid_out <= 1'b1;
        end
        else
          rx_cnt_q <= rx_cnt_q + 4'h1;
      end
    end
  end

  // Line drivers, all registered.
  logic ser_fwd;

  assign ser_fwd = role_q && (st_q != S_OFF) && (st_q != S_WAIT1);

  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      ref_clock_pin_out             <= 1'b0;
      reverse_ref_clock_line_out    <= 1'b0;
      reverse_ref_clock_line_on_out <= 1'b0;
      serial_clock_line_out         <= 1'b0;
      serial_clock_line_on_out      <= 1'b0;
      serial_data_line_out          <= 1'b0;
      serial_data_line_on_out       <= 1'b0;
      link_phase_out                <= PH_OFF;
    end
    else if (ce_in)
    begin
      ref_clock_pin_out <= ser_fwd && wc_in;
      reverse_ref_clock_line_on_out <= !role_q && gen_or_run(st_q);
      reverse_ref_clock_line_out <= role_q ? 1'b0 :
        (st_q == S_INIT) ? ip.level :
        (st_q == S_RUN) && ref_pin;
      serial_clock_line_on_out <= role_q && gen_or_run(st_q);
      serial_clock_line_out <= role_q &&
        ((st_q == S_INIT) ? ip.level : (st_q == S_RUN) && gen_q);
      serial_data_line_on_out <= role_q && (st_q == S_RUN);
      serial_data_line_out    <= role_q && md_q;
      link_phase_out <= role_q ?
        phase_of(wc_on_in, gen_or_run(st_q), st_q == S_RUN) :
        phase_of(gen_or_run(st_q), mc_on_in, md_on_in);
    end
  end

  function automatic logic gen_or_run(input slb_seq_t s);
    gen_or_run = (s == S_INIT) || (s == S_RUN);
  endfunction
endmodule

/* pkg/slb_init_if.sv */
// Purpose: Carries start-up pulse control between sequencer and generator.
// Assumes: All signals belong to the core clock domain.
// Notes:   Tick marks one cycle of whichever clock is being started.
`timescale 1ns/1ps
interface slb_init_if;
  logic start;
  logic tick;
  logic level;
  logic busy;
  logic done;
  modport gen (input start, input tick, output level, output busy,
               output done);
  modport ctl (output start, output tick, input level, input busy,
               input done);
endinterface

/* pkg/slb_pkg.sv */
// Purpose: Shared constants and types for the serial link bring-up block.
// Assumes: One 10 MHz core clock samples every link and pixel clock.
// Notes:   Counts are in cycles of the clock named beside each one.
package slb_pkg;
  // Reference clock edges to wait before driving a clock onward.
  localparam logic [3:0] REF_WAIT_EDGES = 4'h7;
  // Serializer: reference edges from clock output to lock start.
  localparam logic [3:0] LOCK_WAIT_EDGES = 4'h7;
  // Nominal length of each low, high and low start-up state.
  localparam logic [3:0] INIT_STATE_CYC = 4'hc;
  // Serial clock cycles per pixel, two bits per cycle.
  localparam int         SER_CLK_MULT = 5;
  localparam logic [3:0] BITS_PER_WORD = 4'ha;
  localparam int         WORD_W = 10;
  // Core cycles without a pixel edge before the pixel clock is lost.
  localparam logic [11:0] PIX_LOST_CYC = 12'h0ff;
  localparam int         SYNC_W = 20;

  typedef enum logic [3:0] {
    PH_OFF      = 4'b0001,
    PH_INIT_REF = 4'b0010,
    PH_INIT_SER = 4'b0100,
    PH_ACTIVE   = 4'b1000
  } slb_phase_t;

  typedef enum logic [5:0] {
    S_OFF   = 6'b000001,
    S_WAIT1 = 6'b000010,
    S_WAIT2 = 6'b000100,
    S_LOCK  = 6'b001000,
    S_INIT  = 6'b010000,
    S_RUN   = 6'b100000
  } slb_seq_t;

  typedef enum logic [3:0] {
    P_IDLE = 4'b0001,
    P_LOW1 = 4'b0010,
    P_HIGH = 4'b0100,
    P_LOW2 = 4'b1000
  } slb_pulse_t;
endpackage

/* verif/slb_far_ser.sv */
// Purpose: Far serializer model facing the receiving role.
// Assumes: Words come from the bench; taken toggles per latched word.
// Notes:   Released lines show the inverse of their last level.
`timescale 1ns/1ps
module slb_far_ser
  import slb_pkg::*;
#(
  parameter int HALF = 800
)
(
  input  wire logic              rev_on_in,
  input  wire logic              rev_in,
  input  wire logic [WORD_W-1:0] word_in,
  output logic                   sclk_out,
  output logic                   sclk_on_out,
  output logic                   sdat_out,
  output logic                   sdat_on_out,
  output logic                   taken_out
);
  logic [WORD_W-1:0] w;
  initial
  begin
    {sclk_out, sclk_on_out, sdat_out, sdat_on_out, taken_out} = 5'h00;
  end
  // The serial clock is timed on its own, unrelated to the reverse line.
  always @(posedge rev_on_in)
  begin : run
    repeat (14) @(posedge rev_in);
    sclk_on_out = 1'b1;
    sclk_out = 1'b0;
    #(24 * HALF) sclk_out = 1'b1;
    #(24 * HALF) sclk_out = 1'b0;
    #(23 * HALF) sdat_on_out = 1'b1;
    forever
    begin
      w = word_in;
      taken_out = ~taken_out;
      for (int b = 0; b < WORD_W; b++)
      begin
        #(HALF / 2) sdat_out = w[b];
        #(HALF / 2) sclk_out = ~sclk_out;
      end
    end
  end
  always @(negedge rev_on_in)
  begin
    disable run;
    sclk_on_out = 1'b0;
    sdat_on_out = 1'b0;
    sclk_out = ~sclk_out;
    sdat_out = ~sdat_out;
  end
endmodule

/* verif/slb_link_chk.sv */
// Purpose: Port assertions for the link bring-up block.
// Assumes: The role strap only changes while reset is held.
// Notes:   Short delays allow for the two sync flops on each pin.
`timescale 1ns/1ps
module slb_link_chk
  import slb_pkg::*;
(
  input wire logic                clk_in,
  input wire logic                arst_n_in,
  input wire logic                power_down_n_in,
  input wire logic                role_ser_in,
  input wire logic                reverse_ref_clock_line_out,
  input wire logic                reverse_ref_clock_line_on_out,
  input wire logic                serial_clock_line_out,
  input wire logic                serial_clock_line_on_out,
  input wire logic                serial_data_line_on_out,
  input wire logic                rx_valid_out,
  input wire slb_pkg::slb_phase_t link_phase_out
);
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!arst_n_in);
  property p_sleep_off;
    !power_down_n_in [*5] |-> !reverse_ref_clock_line_on_out &&
      !serial_clock_line_on_out && !serial_data_line_on_out;
  endproperty
  a_sleep_off: assert property (p_sleep_off)
    else $error("Link line on during power down.");
  property p_phase_one;
    $onehot(link_phase_out);
  endproperty
  a_phase_one: assert property (p_phase_one)
    else $error("Link phase is not one-hot.");
  property p_data_clk;
    serial_data_line_on_out |-> serial_clock_line_on_out;
  endproperty
  a_data_clk: assert property (p_data_clk)
    else $error("Data line on without serial clock.");
  property p_rev_low;
    $rose(reverse_ref_clock_line_on_out) |->
      !reverse_ref_clock_line_out [*8];
  endproperty
  a_rev_low: assert property (p_rev_low)
    else $error("Reverse line did not start low.");
  property p_ser_low;
    $rose(serial_clock_line_on_out) |-> !serial_clock_line_out [*8];
  endproperty
  a_ser_low: assert property (p_ser_low)
    else $error("Serial clock did not start low.");
  property p_rev_start;
    $rose(reverse_ref_clock_line_on_out) |->
      power_down_n_in && !role_ser_in;
  endproperty
  a_rev_start: assert property (p_rev_start)
    else $error("Reverse line started without cause.");
  property p_des_fwd;
    !role_ser_in |-> !serial_clock_line_on_out;
  endproperty
  a_des_fwd: assert property (p_des_fwd)
    else $error("Receiving end drove the serial clock.");
  property p_valid;
    rx_valid_out |=> !rx_valid_out [*8];
  endproperty
  a_valid: assert property (p_valid)
    else $error("Word valid pulses too close.");
endmodule
bind slb_link_top slb_link_chk u_chk (.*);

/* verif/slb_link_top_tb.sv */
// Purpose: Self-checking bench for the bring-up block in both roles.
// Assumes: Reference clock 800 ns, pixel clock 8 us, core 100 ns.
// Notes:   Spans are in core clocks with one link cycle of slack.
`timescale 1ns/1ps
module slb_link_top_tb;
  import slb_pkg::*;
  localparam int RCP = 8;
  localparam int SCP = 80 / SER_CLK_MULT;
  logic              clk_in, arst_n_in, pdn, role, refc, pclk, rv;
  logic              rv_on, rv_run, tkq, ref_o, rv_o, rv_on_o, sc_o;
  logic              sc_on_o, sd_o, sd_on_o, sc, sc_on, sd, sd_on, tk, rxv;
  logic [WORD_W-1:0] pword, rxw, e;
  logic [WORD_W-1:0] exp_q [$];
  slb_phase_t        ph;
  int                c, r, nrx = 0, comparisons = 0, miscompares = 0;
  int                txn = 0, ntx = 0;
  logic [WORD_W-1:0] txs;
  logic              scp;
  int unsigned       seed;
  wire logic [7:0]   w = {ref_o, rv_on_o, sd_on_o, sc_on_o, sc_on, sc_o,
                          sc, rv_o};
  always #50 clk_in = ~clk_in;
  always #400 refc = ~refc;
  always #400 if (rv_run) rv = ~rv;
  always #4000 pclk = ~pclk;
  slb_link_top uut (.clk_in(clk_in), .arst_n_in(arst_n_in), .ce_in(1'b1),
    .power_down_n_in(pdn), .role_ser_in(role), .ref_clock_pin_in(refc),
    .ref_clock_pin_out(ref_o), .reverse_ref_clock_line_in(rv),
    .reverse_ref_clock_line_on_in(rv_on),
    .reverse_ref_clock_line_out(rv_o),
    .reverse_ref_clock_line_on_out(rv_on_o),
    .serial_clock_line_in(sc), .serial_clock_line_on_in(sc_on),
    .serial_clock_line_out(sc_o), .serial_clock_line_on_out(sc_on_o),
    .serial_data_line_in(sd), .serial_data_line_on_in(sd_on),
    .serial_data_line_out(sd_o), .serial_data_line_on_out(sd_on_o),
    .pixel_clock_in(pclk), .pixel_word_in(pword), .rx_word_out(rxw),
    .rx_valid_out(rxv), .link_phase_out(ph));
  slb_far_ser fs (.rev_on_in(rv_on_o), .rev_in(rv_o), .word_in(pword),
    .sclk_out(sc), .sclk_on_out(sc_on), .sdat_out(sd),
    .sdat_on_out(sd_on), .taken_out(tk));
  task automatic chk(input bit ok, input logic [31:0] g, e);
    comparisons++;
    if (!ok)
    begin
      miscompares++;
      $display("CHECK FAILED at %0t got %h expected %h", $time, g, e);
    end
  endtask
  function automatic bit inr(input int n, input int p);
    return n >= (INIT_STATE_CYC - 1) * p && n <= (INIT_STATE_CYC + 1) * p;
  endfunction
  task automatic step;
    @(posedge clk_in);
    #1;
  endtask
  // Counts cycles while w[s] equals v, and link clock rises meanwhile.
  task automatic span(input int s, input logic v, output int n, m);
    logic p;
    n = 0;
    m = 0;
    p = 1'b1;
    while (w[s] === v && n < 4000)
    begin
      step;
      n++;
      m += int'((role ? rv : refc) === 1'b1 && p === 1'b0);
      p = role ? rv : refc;
    end
  endtask
  // Queue model: a word is expected once the far end has latched it.
  always @(posedge clk_in)
  begin
    if (tk !== tkq)
    begin
      exp_q.push_back(pword);
      pword <= WORD_W'($urandom);
    end
    tkq <= tk;
    if (rxv === 1'b1)
    begin
      nrx++;
      e = exp_q.size() > 0 ? exp_q.pop_front() : ~rxw;
      chk(rxw === e, rxw, e);
    end
  end
  // Serializer role: the word is held, so every sent word must equal it.
  always @(posedge clk_in)
  begin
    if (role !== 1'b1 || sd_on_o !== 1'b1)
      txn = 0;
    else if (sc_o !== scp)
    begin
      txs = {sd_o, txs[WORD_W-1:1]};
      txn++;
      if (txn == WORD_W)
      begin
        txn = 0;
        ntx++;
        chk(txs === pword, txs, pword);
      end
    end
    scp = sc_o;
  end
  task automatic report_and_stop;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial
  begin
    #1000000;
    miscompares++;
    report_and_stop;
  end
  initial
  begin
    clk_in = 1'b0;
    arst_n_in = 1'b0;
    {pdn, role, refc, pclk, rv_on, rv_run, tkq} = 7'h00;
    rv = 1'b1;
    seed = $urandom(32'h8ed4b67e);
    pword = WORD_W'($urandom);
    repeat (4) @(posedge clk_in);
    #1 arst_n_in = 1'b1;
    repeat (4) step;
    chk(ph === PH_OFF, ph, PH_OFF);
    // Release while the reference is high so no edge is split by sync.
    while (refc !== 1'b1) step;
    pdn = 1'b1;
    span(6, 1'b0, c, r);
    chk(r == 7, r, 7);
    span(0, 1'b0, c, r);
    chk(inr(c, RCP), c, INIT_STATE_CYC * RCP);
    chk(ph === PH_INIT_REF, ph, PH_INIT_REF);
    span(0, 1'b1, c, r);
    chk(inr(c, RCP), c, INIT_STATE_CYC * RCP);
    span(0, 1'b0, c, r);
    chk(inr(c, RCP), c, INIT_STATE_CYC * RCP);
    span(3, 1'b0, c, r);
    span(1, 1'b0, c, r);
    chk(ph === PH_INIT_SER, ph, PH_INIT_SER);
    c = 0;
    while (nrx < 6 && c < 9000)
    begin
      step;
      c++;
    end
    chk(nrx >= 6, nrx, 6);
    chk(ph === PH_ACTIVE, ph, PH_ACTIVE);
    repeat ($urandom_range(70, 10)) step;
    pdn = 1'b0;
    repeat (8) step;
    exp_q.delete();
    chk(ph === PH_OFF && rv_on_o === 1'b0, ph, PH_OFF);
    arst_n_in = 1'b0;
    role = 1'b1;
    repeat (4) step;
    arst_n_in = 1'b1;
    repeat (4) step;
    pdn = 1'b1;
    fork
      begin
        rv = 1'b0;
        rv_on = 1'b1;
        #9600 rv = 1'b1;
        #9600 rv = 1'b0;
        #9600 rv_run = 1'b1;
      end
    join_none
    span(7, 1'b0, c, r);
    chk(r >= 7 && r <= 8, r, 7);
    span(4, 1'b0, c, r);
    span(2, 1'b0, c, r);
    chk(inr(c, SCP), c, INIT_STATE_CYC * SCP);
    span(2, 1'b1, c, r);
    chk(inr(c, SCP), c, INIT_STATE_CYC * SCP);
    span(5, 1'b0, c, r);
    repeat (4) step;
    chk(ph === PH_ACTIVE, ph, PH_ACTIVE);
    c = 0;
    while (ntx < 3 && c < 400)
    begin
      step;
      c++;
    end
    chk(ntx >= 3, ntx, 3);
    pdn = 1'b0;
    repeat (6) step;
    chk(w[5:4] === 2'b00, w, 0);
    report_and_stop;
  end
endmodule
